// *** ser_regs.svh ***
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

// point counts and store sizes
`define SER_NPTS 8
`define SER_EVT_DEPTH 12'h800
`define SER_SEQ_DEPTH 11'h400

// timing figures in their own units
`define SER_CLK_NS 25
`define SER_MS_NS 1000000
`define SER_DEB_MS 20

// message check polynomial, x^8 + x^2 + x + 1
`define SER_CRC_POLY 8'h07

// point code layout: {invalid, state}
`define SER_CODE_RST 2'h0
`define SER_CODE_INV 1

// exception reply flag positions
`define SER_FL_PEND 0
`define SER_FL_OVF_EVT 1
`define SER_FL_OVF_SEQ 2
`define SER_FL_PWR_RET 3
`define SER_FL_FAULT 4
`define SER_FL_MOM 5
`define SER_FL_ALARM 6
`define SER_FL_TRIP 7

`endif

// *** ser_pkg.sv ***
package ser_pkg;

  typedef enum logic [2:0] {
    SER_M_SINGLE,
    SER_M_COS,
    SER_M_SEQ_TAG,
    SER_M_ALARM,
    SER_M_TAP,
    SER_M_TRIP
  } ser_mode_t;

  typedef enum logic [2:0] {
    SER_CMD_EXC,
    SER_CMD_UPD,
    SER_CMD_RD_EVT,
    SER_CMD_ACK_EVT,
    SER_CMD_RD_SEQ,
    SER_CMD_ACK_SEQ
  } ser_cmd_t;

  typedef struct packed {
    logic [1:0] stable;
    logic [19:0] cnt;
    logic chg;
  } ser_filt_st_t;

  typedef struct packed {
    logic [15:0] ms_cnt;
    logic [15:0] ms_time;
    logic [7:0] pend;
    logic [7:0][15:0] ptime;
    logic [7:0] mom;
    logic alarm;
    logic trip;
    logic pwr_ret;
    logic ovf_evt;
    logic ovf_seq;
    logic [10:0] evt_wr;
    logic [10:0] evt_rd;
    logic [11:0] evt_cnt;
    logic [9:0] seq_wr;
    logic [9:0] seq_rd;
    logic [10:0] seq_cnt;
    logic rsp_v;
    logic [31:0] rsp_data;
    logic [7:0] rsp_crc;
    logic crc_err;
  } ser_top_st_t;

endpackage

// *** ser_pt_if.sv ***
`timescale 1ns/10ps
interface ser_pt_if;
  logic [1:0] raw;
  logic [1:0] stable;
  logic chg;
  modport filt (input raw, output stable, output chg);
  modport top (output raw, input stable, input chg);
endinterface

// *** ser_filt.sv ***
`timescale 1ns/10ps
`include "ser_regs.svh"
module ser_filt import ser_pkg::*; #(
  parameter int DEB_CYC = 800000
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // one point
  ser_pt_if.filt pt
);

  ser_filt_st_t q;
  ser_filt_st_t d;

  // the input must differ from the accepted code for the whole window; any return to the
  // accepted code restarts it, which is what gives the hysteresis
  always_comb begin
    d = q;
    d.chg = 1'b0;
    if (pt.raw == q.stable) begin
      d.cnt = '0; // RQ16
    end else if (q.cnt == 20'(DEB_CYC - 1)) begin
      d.stable = pt.raw; // RQ9
      d.cnt = '0;
      d.chg = 1'b1;
    end else begin
      d.cnt = q.cnt + 20'h0_0001;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '{stable: `SER_CODE_RST, cnt: '0, chg: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pt.stable = q.stable;
  assign pt.chg = q.chg;

endmodule

// *** ser_top.sv ***
// Behaviour
// RQ1: device only answers requests, never transmits unprompted
// RQ2: master opens every exchange; device waits for a request
// RQ3: power return, fault, pending changes reported inside poll replies
// RQ4: exception scan reply carries only change indication flags
// RQ5: master fetches changed points with a further request
// RQ6: pending indication stays until master acknowledges the changed data
// RQ7: update scan returns present state of every point
// RQ8: replies carry CRC; requests with bad CRC are rejected
// RQ9: each input has its own independent debounce filter
// RQ10: events time tagged with one millisecond resolution
// RQ11: change events kept in a store of at least 2000 entries
// RQ12: change store overflow recorded and reported to master
// RQ13: each input configurable as one of six functions
// RQ14: sequence tagged inputs also use a separate 1024 entry store
// RQ15: tap inputs read as groups of four lines, one BCD digit
// RQ16: hysteresis keeps brief disturbances from reporting a change
// RQ17: breaker point from two complementary contacts, valid if exactly one
// RQ18: both contacts open or both closed reported invalid
// RQ19: re-closing breakers get momentary capture, others do not
// RQ20: momentary capture takes operations of 20 ms or more only
// RQ21: per point polarity for single contact points
// RQ22: stores are FIFO, oldest first, removed only on acknowledge
// RQ23: time tag sampled from free running ms counter at acceptance
`timescale 1ns/10ps
`include "ser_regs.svh"
module ser_top import ser_pkg::*; #(
  parameter int MS_CYC = `SER_MS_NS / `SER_CLK_NS,
  parameter int DEB_CYC = `SER_DEB_MS * MS_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // contact inputs, b is the complementary contact of dual points
  input wire logic [7:0] i_contact_a,
  input wire logic [7:0] i_contact_b,
  // point configuration
  input wire ser_mode_t [7:0] i_point_mode,
  input wire logic [7:0] i_dual,
  input wire logic [7:0] i_reclose,
  input wire logic [7:0] i_invert,
  // station condition
  input wire logic i_fault,
  // master request
  input wire logic i_req_valid,
  input wire logic [7:0] i_req_byte,
  input wire logic [7:0] i_req_crc,
  // reply to master
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_data,
  output logic [7:0] o_rsp_crc,
  output logic o_crc_err
);

  ser_top_st_t q;
  ser_top_st_t d;

  logic [23:0] evt_mem [0:`SER_EVT_DEPTH-1];
  logic [23:0] seq_mem [0:`SER_SEQ_DEPTH-1];

  logic [7:0][1:0] stab;
  logic [7:0] stv;
  logic [7:0] chgv;
  logic push_evt;
  logic push_seq;
  logic [23:0] entry;

  function automatic logic [7:0] ser_crc8(logic [31:0] dat);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ dat[i]) begin
        c = {c[6:0], 1'b0} ^ `SER_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // lowest pending point, {found, index}
  function automatic logic [3:0] ser_first(logic [7:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  ser_pt_if pif [8] ();

  for (genvar g = 0; g < `SER_NPTS; g++) begin : g_pt
    // dual points are invalid when both contacts agree
    assign pif[g].raw = i_dual[g] ?
      {i_contact_a[g] == i_contact_b[g], i_contact_a[g]} : // RQ17 RQ18
      {1'b0, i_contact_a[g] ^ i_invert[g]}; // RQ21
    ser_filt #(.DEB_CYC(DEB_CYC)) u_filt (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .pt(pif[g])
    );
    assign stab[g] = pif[g].stable;
    assign stv[g] = pif[g].stable[0];
    assign chgv[g] = pif[g].chg;
  end

  logic [7:0] flags;
  logic [7:0] ev_pts;
  logic [7:0] alarm_pts;
  logic [7:0] trip_pts;
  logic [7:0] seq_pts;
  logic [7:0] tap_pts;
  logic [3:0] first;
  logic [2:0] sel;
  logic evt_full;
  logic seq_full;
  logic evt_some;
  logic seq_some;
  logic pop_evt;
  logic pop_seq;
  logic clr_ack;
  logic clr_mom;
  logic req_ok;

  always_comb begin
    for (int i = 0; i < `SER_NPTS; i++) begin
      ev_pts[i] = i_point_mode[i] != SER_M_SINGLE; // RQ13
      alarm_pts[i] = i_point_mode[i] == SER_M_ALARM;
      trip_pts[i] = i_point_mode[i] == SER_M_TRIP;
      seq_pts[i] = i_point_mode[i] == SER_M_SEQ_TAG;
      tap_pts[i] = i_point_mode[i] == SER_M_TAP;
    end
  end

  assign evt_full = q.evt_cnt == `SER_EVT_DEPTH;
  assign seq_full = q.seq_cnt == `SER_SEQ_DEPTH;
  assign evt_some = q.evt_cnt != 12'h000;
  assign seq_some = q.seq_cnt != 11'h000;
  assign first = ser_first(q.pend);
  assign sel = first[2:0];

  // pending holds while a point is unstored or the event store is not empty
  assign flags = {q.trip, q.alarm, |q.mom, i_fault, q.pwr_ret,
                  q.ovf_seq, q.ovf_evt, evt_some | (|q.pend)}; // RQ3 RQ6

  always_comb begin
    d = q;
    d.rsp_v = 1'b0;
    d.crc_err = 1'b0;
    push_evt = 1'b0;
    push_seq = 1'b0;
    pop_evt = 1'b0;
    pop_seq = 1'b0;
    clr_ack = 1'b0;
    clr_mom = 1'b0;
    entry = '0;
    req_ok = i_req_valid && (ser_crc8({24'h00_0000, i_req_byte}) == i_req_crc);

    // free running millisecond time base
    if (q.ms_cnt == 16'(MS_CYC - 1)) begin
      d.ms_cnt = '0;
      d.ms_time = q.ms_time + 16'h0001; // RQ10
    end else begin
      d.ms_cnt = q.ms_cnt + 16'h0001;
    end

    // requests; a reply only ever follows an accepted request
    if (i_req_valid && !req_ok) begin
      d.crc_err = 1'b1; // RQ8
    end else if (req_ok) begin
      d.rsp_v = 1'b1; // RQ1 RQ2
      case (ser_cmd_t'(i_req_byte[2:0]))
        SER_CMD_EXC: begin
          d.rsp_data = {24'h00_0000, flags}; // RQ4
        end
        SER_CMD_UPD: begin
          d.rsp_data = {8'h00, q.mom, stab}; // RQ7
          clr_mom = 1'b1;
        end
        SER_CMD_RD_EVT: begin
          d.rsp_data = {7'h00, evt_some, evt_mem[q.evt_rd]}; // RQ5 RQ22
        end
        SER_CMD_ACK_EVT: begin
          d.rsp_data = {24'h00_0000, flags};
          pop_evt = evt_some; // RQ22
          clr_ack = 1'b1; // RQ6
        end
        SER_CMD_RD_SEQ: begin
          d.rsp_data = {7'h00, seq_some, seq_mem[q.seq_rd]};
        end
        SER_CMD_ACK_SEQ: begin
          d.rsp_data = {24'h00_0000, flags};
          pop_seq = seq_some;
          d.ovf_seq = 1'b0;
        end
        default: begin
          // unknown command still answers, with the flags
          d.rsp_data = {24'h00_0000, flags};
        end
      endcase
      d.rsp_crc = ser_crc8(d.rsp_data); // RQ8
    end

    if (clr_ack) begin
      d.alarm = 1'b0;
      d.trip = 1'b0;
      d.pwr_ret = 1'b0;
      d.ovf_evt = 1'b0;
    end

    // one pending point is stored per cycle, lowest index first
    if (first[3]) begin
      entry = {q.ptime[sel], sel, 5'h00};
      if (tap_pts[sel]) begin
        entry[4:0] = {1'b1, sel[2] ? stv[7:4] : stv[3:0]}; // RQ15
      end else begin
        entry[1:0] = stab[sel];
      end
      if (evt_full) begin
        d.ovf_evt = 1'b1; // RQ12
      end else begin
        push_evt = 1'b1; // RQ11
      end
      if (seq_pts[sel]) begin
        if (seq_full) begin
          d.ovf_seq = 1'b1;
        end else begin
          push_seq = 1'b1; // RQ14
        end
      end
      d.pend[sel] = 1'b0;
    end

    // sets after clears so that a coincident event is never lost
    for (int i = 0; i < `SER_NPTS; i++) begin
      if (chgv[i] && ev_pts[i]) begin
        d.pend[i] = 1'b1;
        d.ptime[i] = q.ms_time; // RQ23
      end
    end
    if (clr_mom) begin
      d.mom = '0;
    end
    d.mom = d.mom | (chgv & i_dual & i_reclose); // RQ19 RQ20
    d.alarm = d.alarm | (|(chgv & alarm_pts));
    d.trip = d.trip | (|(chgv & trip_pts));

    // fifo pointers and fill counts
    if (push_evt) begin
      d.evt_wr = q.evt_wr + 11'h001;
    end
    if (pop_evt) begin
      d.evt_rd = q.evt_rd + 11'h001;
    end
    if (push_evt && !pop_evt) begin
      d.evt_cnt = q.evt_cnt + 12'h001;
    end else if (pop_evt && !push_evt) begin
      d.evt_cnt = q.evt_cnt - 12'h001;
    end
    if (push_seq) begin
      d.seq_wr = q.seq_wr + 10'h001;
    end
    if (pop_seq) begin
      d.seq_rd = q.seq_rd + 10'h001;
    end
    if (push_seq && !pop_seq) begin
      d.seq_cnt = q.seq_cnt + 11'h001;
    end else if (pop_seq && !push_seq) begin
      d.seq_cnt = q.seq_cnt - 11'h001;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      // a restart is itself reported until acknowledged
      q.pwr_ret <= 1'b1; // RQ3
    end else begin
      q <= d;
    end
  end

  // stores hold no reset: the counts say what is valid
  always_ff @(posedge i_sys_clk) begin
    if (push_evt) begin
      evt_mem[q.evt_wr] <= entry;
    end
    if (push_seq) begin
      seq_mem[q.seq_wr] <= entry;
    end
  end

  assign o_rsp_valid = q.rsp_v;
  assign o_rsp_data = q.rsp_data;
  assign o_rsp_crc = q.rsp_crc;
  assign o_crc_err = q.crc_err;

endmodule

// *** ser_top_sva.sv ***
`timescale 1ns/10ps
`include "ser_regs.svh"
module ser_top_sva import ser_pkg::*; #(
  parameter int MS_CYC = 10,
  parameter int DEB_CYC = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // request side
  input wire logic i_fault,
  input wire logic i_req_valid,
  input wire logic [7:0] i_req_byte,
  input wire logic [7:0] i_req_crc,
  // reply side
  input wire logic o_rsp_valid,
  input wire logic [31:0] o_rsp_data,
  input wire logic [7:0] o_rsp_crc,
  input wire logic o_crc_err
);
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SER_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  logic ok;
  logic exc;
  logic upd;
  assign ok = i_req_valid && (i_req_crc == crc8({24'h00_0000, i_req_byte}));
  assign exc = ok && (i_req_byte[2:0] == SER_CMD_EXC);
  assign upd = ok && (i_req_byte[2:0] == SER_CMD_UPD);

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  property p_only_req; o_rsp_valid |-> $past(ok); endproperty
  property p_err_req; o_crc_err |-> $past(i_req_valid) && !$past(ok);
  endproperty
  property p_ans; ok |=> o_rsp_valid && !o_crc_err; endproperty
  property p_rej;
    i_req_valid && !ok |=> o_crc_err && !o_rsp_valid && $stable(o_rsp_data);
  endproperty
  property p_crc_out; o_rsp_valid |-> o_rsp_crc == crc8(o_rsp_data);
  endproperty
  property p_exc; exc |=> o_rsp_data[31:8] == '0; endproperty
  property p_fault; exc |=> o_rsp_data[4] == $past(i_fault); endproperty
  property p_upd; upd |=> o_rsp_data[31:24] == '0; endproperty
  property p_hold;
    !o_rsp_valid |-> $stable(o_rsp_data) && $stable(o_rsp_crc);
  endproperty

  a_only_req: assert property (p_only_req) else $error("reply unasked");
  a_err_req: assert property (p_err_req) else $error("stray crc error");
  a_ans: assert property (p_ans) else $error("good request unanswered");
  a_rej: assert property (p_rej) else $error("bad request accepted");
  a_crc_out: assert property (p_crc_out) else $error("reply crc wrong");
  a_exc: assert property (p_exc) else $error("exception reply too wide");
  a_fault: assert property (p_fault) else $error("fault flag wrong");
  a_upd: assert property (p_upd) else $error("update reply upper bits");
  a_hold: assert property (p_hold) else $error("reply changed unasked");

  c_exc: cover property (exc ##1 o_rsp_valid);
  c_upd: cover property (upd ##1 o_rsp_valid);
  c_err: cover property (o_crc_err);
  c_mom: cover property (upd ##1 o_rsp_valid && o_rsp_data[23:16] != '0);
endmodule

bind ser_top ser_top_sva #(.MS_CYC(MS_CYC), .DEB_CYC(DEB_CYC)) u_sva (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_fault(i_fault),
  .i_req_valid(i_req_valid), .i_req_byte(i_req_byte),
  .i_req_crc(i_req_crc), .o_rsp_valid(o_rsp_valid),
  .o_rsp_data(o_rsp_data), .o_rsp_crc(o_rsp_crc), .o_crc_err(o_crc_err));

// *** ser_mst.sv ***
`timescale 1ns/10ps
`include "ser_regs.svh"
module ser_mst import ser_pkg::*; (
  // clock
  input wire logic i_sys_clk,
  // request to the station
  output logic o_req_valid = 1'b0,
  output logic [7:0] o_req_byte = 8'h00,
  output logic [7:0] o_req_crc = 8'h00
);
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SER_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // every exchange starts here; bad flips the check code on purpose
  task automatic send(input ser_cmd_t c, input logic bad);
    @(posedge i_sys_clk);
    #2;
    o_req_valid = 1'b1;
    o_req_byte = {5'h00, c};
    o_req_crc = crc8({24'h00_0000, 5'h00, c}) ^ {7'h00, bad};
    @(posedge i_sys_clk);
    #2;
    o_req_valid = 1'b0;
    // released lines never keep the last value
    o_req_byte = ~o_req_byte;
    o_req_crc = ~o_req_crc;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top import ser_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ca = 8'h00;
  logic [7:0] cb = 8'h06;
  logic [7:0] inv = 8'h08;
  // point 2 is a re-closing breaker, so it gets momentary capture
  logic [7:0] rcl = 8'h04;
  logic fault = 1'b0;
  ser_mode_t [7:0] mode = '{SER_M_TRIP, SER_M_TAP, SER_M_ALARM, SER_M_SEQ_TAG,
    SER_M_SINGLE, SER_M_SINGLE, SER_M_SINGLE, SER_M_COS};
  logic rv;
  logic [7:0] rb;
  logic [7:0] rc;
  logic ov;
  logic oe;
  logic [31:0] od;
  logic [7:0] oc;
  int mismatches = 0;
  int checks = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  ser_mst mst (.i_sys_clk(clk), .o_req_valid(rv), .o_req_byte(rb),
    .o_req_crc(rc));

  ser_top #(.MS_CYC(10), .DEB_CYC(4)) dut (
    .i_sys_clk(clk), .i_reset(rst), .i_contact_a(ca), .i_contact_b(cb),
    .i_point_mode(mode), .i_dual(8'h06), .i_reclose(rcl), .i_invert(inv),
    .i_fault(fault), .i_req_valid(rv), .i_req_byte(rb), .i_req_crc(rc),
    .o_rsp_valid(ov), .o_rsp_data(od), .o_rsp_crc(oc), .o_crc_err(oe));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one request, then the reply (or refusal) compared under a mask
  task automatic req(input ser_cmd_t c, input logic bad,
                     input logic [31:0] exp, input logic [31:0] msk);
    mst.send(c, bad);
    for (int n = 0; n < 3 && !(ov || oe); n++) begin
      @(posedge clk);
      #2;
    end
    if (!(ov || oe)) begin
      mismatches++;
      $display("[FAIL] %0t no reply", $time);
      finish_test();
    end
    `CHK(ov, !bad)
    `CHK(oe, bad)
    `CHK(od & msk, exp)
    `CHK(oc, mst.crc8(od))
  endtask

  task automatic contacts(input logic [7:0] a, input logic [7:0] b,
                          input int hold);
    ca = a;
    cb = b;
    repeat (hold) @(posedge clk);
    #2;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    repeat (12) @(posedge clk);
    req(SER_CMD_EXC, 1'b0, 32'h0000_0008, '1);
    req(SER_CMD_UPD, 1'b0, 32'h0000_0040, '1);
    req(SER_CMD_EXC, 1'b1, 32'h0000_0000, '0);
    // two cycles is shorter than the filter time
    contacts(8'h07, 8'h02, 2);
    contacts(8'h00, 8'h06, 10);
    req(SER_CMD_EXC, 1'b0, 32'h0000_0008, '1);
    req(SER_CMD_UPD, 1'b0, 32'h0000_0040, '1);
    contacts(8'h07, 8'h02, 12);
    req(SER_CMD_EXC, 1'b0, 32'h0000_0029, '1);
    req(SER_CMD_UPD, 1'b0, 32'h0004_005d, '1);
    req(SER_CMD_RD_EVT, 1'b0, 32'h0100_0001, 32'hff00_00ff);
    req(SER_CMD_RD_SEQ, 1'b0, 32'h0000_0000, 32'h0100_0000);
    req(SER_CMD_EXC, 1'b0, 32'h0000_0009, '1);
    req(SER_CMD_ACK_EVT, 1'b0, 32'h0000_0009, '1);
    req(SER_CMD_EXC, 1'b0, 32'h0000_0000, '1);
    req(SER_CMD_ACK_SEQ, 1'b0, 32'h0000_0000, '1);
    // points 4 to 7 change together and are stored lowest index first
    contacts(8'hf7, 8'h02, 16);
    req(SER_CMD_EXC, 1'b0, 32'h0000_00c1, '1);
    req(SER_CMD_RD_SEQ, 1'b0, 32'h0100_0081, 32'hff00_00ff);
    req(SER_CMD_RD_EVT, 1'b0, 32'h0100_0081, 32'hff00_00ff);
    req(SER_CMD_ACK_EVT, 1'b0, 32'h0000_00c1, '1);
    req(SER_CMD_RD_EVT, 1'b0, 32'h0100_00a1, 32'hff00_00ff);
    req(SER_CMD_ACK_EVT, 1'b0, 32'h0000_0001, '1);
    req(SER_CMD_RD_EVT, 1'b0, 32'h0100_00df, 32'hff00_00ff);
    fault = 1'b1;
    req(SER_CMD_EXC, 1'b0, 32'h0000_0011, '1);
    finish_test();
  end
endmodule
